// ---- common/pfl_regs.svh ----
`ifndef PFL_REGS_SVH
`define PFL_REGS_SVH

// ==========================================================
// register offsets
`define PFL_ADDR_W            8
`define PFL_CONV_FLAGS_OFS    8'h22
`define PFL_BOOST_FLAGS_OFS   8'h23
`define PFL_MON_FLAGS_OFS     8'h24
`define PFL_TOP_STATUS_OFS    8'h25

// ==========================================================
// converter event flag positions
`define PFL_CONV_B1_GOOD_BIT  6
`define PFL_CONV_B1_SHORT_BIT 5
`define PFL_CONV_B1_LIMIT_BIT 4
`define PFL_CONV_B0_GOOD_BIT  2
`define PFL_CONV_B0_SHORT_BIT 1
`define PFL_CONV_B0_LIMIT_BIT 0
`define PFL_CONV_FLAG_MASK    8'h77

// ==========================================================
// boost event flag positions
`define PFL_BOOST_GOOD_BIT    2
`define PFL_BOOST_SHORT_BIT   1
`define PFL_BOOST_LIMIT_BIT   0
`define PFL_BOOST_FLAG_MASK   8'h07

// ==========================================================
// monitor event flag positions
`define PFL_MON2_GOOD_BIT     4
`define PFL_MON1_GOOD_BIT     2
`define PFL_ANA_GOOD_BIT      0
`define PFL_MON_FLAG_MASK     8'h15

// ==========================================================
// top live status positions
`define PFL_TOP_SYNC_BIT      3
`define PFL_TOP_TSD_BIT       2
`define PFL_TOP_TWARN_BIT     1
`define PFL_TOP_OVP_BIT       0

// ==========================================================
// reset values
`define PFL_FLAGS_RESET       8'h00
`define PFL_TOP_RESET         8'h00

`endif

// ---- common/pfl_pkg.sv ----
package pfl_pkg;

	typedef struct packed
	{
		logic [7:0] conv_flags;
		logic [7:0] boost_flags;
		logic [7:0] mon_flags;
		logic [7:0] top_status;
		logic [7:0] rdata;
	} pfl_state_type;

endpackage

// ---- core/pfl_fault_latch.sv ----
`include "pfl_regs.svh"

// Operation
// - second step-down good event sets bit 6
// - second step-down short event sets bit 5
// - second step-down limit event sets bit 4
// - first step-down good event sets bit 2
// - first step-down short event sets bit 1
// - first step-down limit event sets bit 0
// - boost good event sets boost bit 2
// - boost short event sets boost bit 1
// - boost limit event sets boost bit 0
// - second monitor good event sets bit 4
// - first monitor good event sets bit 2
// - analog supply good event sets bit 0
// - top bit 3 high when sync clock invalid
// - top bit 2 follows thermal shutdown
// - top bit 1 follows thermal warning
// - top bit 0 follows input overvoltage
// - top bits 7-4 read zero, reset zero
// - converter summary high while any flag set
// - boost summary high while any flag set
// - monitor summary high while any flag set
module pfl_fault_latch
(
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	input  wire logic       second_step_down_good_evt,
	input  wire logic       second_step_down_short_evt,
	input  wire logic       second_step_down_limit_evt,
	input  wire logic       first_step_down_good_evt,
	input  wire logic       first_step_down_short_evt,
	input  wire logic       first_step_down_limit_evt,
	input  wire logic       step_up_good_evt,
	input  wire logic       step_up_short_evt,
	input  wire logic       step_up_limit_evt,
	input  wire logic       second_ext_monitor_good_evt,
	input  wire logic       first_ext_monitor_good_evt,
	input  wire logic       analog_supply_good_evt,
	input  wire logic       sync_clock_input_invalid,
	input  wire logic       thermal_shutdown_live,
	input  wire logic       thermal_warning_live,
	input  wire logic       input_overvoltage_live,
	output logic            converter_summary_irq,
	output logic            step_up_summary_irq,
	output logic            monitor_summary_irq
);

	pfl_pkg::pfl_state_type state_q;
	pfl_pkg::pfl_state_type state_d;
	logic [7:0]             conv_evt;
	logic [7:0]             boost_evt;
	logic [7:0]             mon_evt;
	logic [7:0]             top_live;

	// ==========================================================
	// event vectors
	// short-circuit detection (undervoltage and the 1 ms start-up
	// timeout) lives in the analog side; it arrives here as one pulse
	always_comb
	begin
		conv_evt                            = 8'h00;
		conv_evt[`PFL_CONV_B1_GOOD_BIT]     = second_step_down_good_evt;
		conv_evt[`PFL_CONV_B1_SHORT_BIT]    = second_step_down_short_evt;
		conv_evt[`PFL_CONV_B1_LIMIT_BIT]    = second_step_down_limit_evt;
		conv_evt[`PFL_CONV_B0_GOOD_BIT]     = first_step_down_good_evt;
		conv_evt[`PFL_CONV_B0_SHORT_BIT]    = first_step_down_short_evt;
		conv_evt[`PFL_CONV_B0_LIMIT_BIT]    = first_step_down_limit_evt;
		boost_evt                           = 8'h00;
		boost_evt[`PFL_BOOST_GOOD_BIT]      = step_up_good_evt;
		boost_evt[`PFL_BOOST_SHORT_BIT]     = step_up_short_evt;
		boost_evt[`PFL_BOOST_LIMIT_BIT]     = step_up_limit_evt;
		mon_evt                             = 8'h00;
		mon_evt[`PFL_MON2_GOOD_BIT]         = second_ext_monitor_good_evt;
		mon_evt[`PFL_MON1_GOOD_BIT]         = first_ext_monitor_good_evt;
		mon_evt[`PFL_ANA_GOOD_BIT]          = analog_supply_good_evt;
		top_live                            = 8'h00;
		top_live[`PFL_TOP_SYNC_BIT]         = sync_clock_input_invalid;
		top_live[`PFL_TOP_TSD_BIT]          = thermal_shutdown_live;
		top_live[`PFL_TOP_TWARN_BIT]        = thermal_warning_live;
		top_live[`PFL_TOP_OVP_BIT]          = input_overvoltage_live;
	end

	// ==========================================================
	// flag update
	// flag bits: set | (held & ~w1c); reserved bits: plain storage
	function automatic logic [7:0] pfl_update
	(
		input logic [7:0] cur,
		input logic [7:0] evt,
		input logic [7:0] mask,
		input logic       wr,
		input logic [7:0] wdata
	);
		logic [7:0] clr;
		clr = wr ? wdata : 8'h00;
		pfl_update = (evt & mask) | (cur & mask & ~clr)
			| (mask ^ 8'hff) & (wr ? wdata : cur);
	endfunction

	always_comb
	begin
		state_d            = state_q;
		state_d.conv_flags = pfl_update(state_q.conv_flags, conv_evt, `PFL_CONV_FLAG_MASK,
			reg_write && reg_addr == `PFL_CONV_FLAGS_OFS, reg_wdata);
		state_d.boost_flags = pfl_update(state_q.boost_flags, boost_evt, `PFL_BOOST_FLAG_MASK,
			reg_write && reg_addr == `PFL_BOOST_FLAGS_OFS, reg_wdata);
		state_d.mon_flags  = pfl_update(state_q.mon_flags, mon_evt, `PFL_MON_FLAG_MASK,
			reg_write && reg_addr == `PFL_MON_FLAGS_OFS, reg_wdata);
		// registered copy of live inputs keeps read data glitch free
		state_d.top_status = top_live;
		state_d.rdata      = 8'h00;
		if (reg_read)
		begin
			unique case (reg_addr)
				`PFL_CONV_FLAGS_OFS:  state_d.rdata = state_q.conv_flags;
				`PFL_BOOST_FLAGS_OFS: state_d.rdata = state_q.boost_flags;
				`PFL_MON_FLAGS_OFS:   state_d.rdata = state_q.mon_flags;
				`PFL_TOP_STATUS_OFS:  state_d.rdata = state_q.top_status;
				default:              state_d.rdata = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q.conv_flags  <= `PFL_FLAGS_RESET;
			state_q.boost_flags <= `PFL_FLAGS_RESET;
			state_q.mon_flags   <= `PFL_FLAGS_RESET;
			state_q.top_status  <= `PFL_TOP_RESET;
			state_q.rdata       <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// outputs
	// summaries ignore reserved storage bits
	assign reg_rdata             = state_q.rdata;
	assign converter_summary_irq = |(state_q.conv_flags & `PFL_CONV_FLAG_MASK);
	assign step_up_summary_irq   = |(state_q.boost_flags & `PFL_BOOST_FLAG_MASK);
	assign monitor_summary_irq   = |(state_q.mon_flags & `PFL_MON_FLAG_MASK);

endmodule // pfl_fault_latch

// ---- tb/pfl_fault_latch_monitor.sv ----
module pfl_fault_latch_monitor
(
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       first_step_down_good_evt,
	input wire logic       step_up_limit_evt,
	input wire logic       analog_supply_good_evt,
	input wire logic       thermal_shutdown_live,
	input wire logic       converter_summary_irq,
	input wire logic       step_up_summary_irq,
	input wire logic       monitor_summary_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// summaries
	a_conv_set: assert property (first_step_down_good_evt |=> converter_summary_irq) else $error("conv");
	a_boost_set: assert property (step_up_limit_evt |=> step_up_summary_irq) else $error("boost");
	a_mon_set: assert property (analog_supply_good_evt |=> monitor_summary_irq) else $error("mon");
	a_conv_hold: assert property (converter_summary_irq && !(reg_write && reg_addr == 8'h22)
		|=> converter_summary_irq) else $error("conv hold");
	a_mon_hold: assert property (monitor_summary_irq && !(reg_write && reg_addr == 8'h24)
		|=> monitor_summary_irq) else $error("mon hold");
	a_conv_read: assert property ($past(reg_read) && $past(reg_addr) == 8'h22
		|-> (|(reg_rdata & 8'h77)) == $past(converter_summary_irq)) else $error("conv read");
	// ==========
	// live status
	a_top_rsv: assert property ($past(reg_read) && $past(reg_addr) == 8'h25
		|-> reg_rdata[7:4] == 4'h0) else $error("top rsv");
	a_tsd_live: assert property ($past(reg_read) && $past(reg_addr) == 8'h25
		|-> reg_rdata[2] == $past(thermal_shutdown_live, 2)) else $error("tsd");
	// read data stand one cycle only, zero otherwise
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00) else $error("rdata idle");
endmodule // pfl_fault_latch_monitor

bind pfl_fault_latch pfl_fault_latch_monitor u_monitor (.*);

// ---- tb/pfl_host_model.sv ----
module pfl_host_model
(
	input  wire logic       sys_clk,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_write,
	output logic            reg_read,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reg_addr, reg_wdata, reg_write, reg_read} = '0;
	// ==========
	// bus cycles
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
endmodule // pfl_host_model

// ---- tb/pfl_fault_latch_tb.sv ----
module pfl_fault_latch_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [11:0] evt = '0;
	logic [3:0]  live = '0;
	logic [7:0]  d;
	wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
	wire         reg_write, reg_read;
	wire  [2:0]  irq;
	int          mismatches = 0;
	int          n_compared = 0;
	byte         bp[12] = '{0, 1, 2, 4, 5, 6, 0, 1, 2, 0, 2, 4};
	pfl_host_model host(.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata));
	pfl_fault_latch dut(.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.first_step_down_limit_evt(evt[0]), .first_step_down_short_evt(evt[1]), .first_step_down_good_evt(evt[2]),
		.second_step_down_limit_evt(evt[3]), .second_step_down_short_evt(evt[4]), .second_step_down_good_evt(evt[5]),
		.step_up_limit_evt(evt[6]), .step_up_short_evt(evt[7]), .step_up_good_evt(evt[8]),
		.analog_supply_good_evt(evt[9]), .first_ext_monitor_good_evt(evt[10]), .second_ext_monitor_good_evt(evt[11]),
		.input_overvoltage_live(live[0]), .thermal_warning_live(live[1]), .thermal_shutdown_live(live[2]),
		.sync_clock_input_invalid(live[3]), .converter_summary_irq(irq[0]), .step_up_summary_irq(irq[1]),
		.monitor_summary_irq(irq[2]));
	initial forever #20 sys_clk = ~sys_clk;
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task t_rsv;
		logic [7:0] r[3] = '{8'h88, 8'hf8, 8'hea};
		for (int i = 0; i < 3; i++)
		begin
			host.rd(8'h22 + 8'(i), d);
			chk("reset", 8'h00, d);
			host.wr(8'h22 + 8'(i), 8'hff);
			host.rd(8'h22 + 8'(i), d);
			chk("reserved", r[i], d);
			chk("no summary", 8'h00, {5'h0, irq});
			host.wr(8'h22 + 8'(i), 8'h00);
		end
	endtask
	task t_flags;
		logic [7:0] a;
		logic [7:0] m;
		int         g;
		for (int i = 0; i < 12; i++)
		begin
			g = (i < 6) ? 0 : (i < 9) ? 1 : 2;
			a = 8'h22 + 8'(g);
			m = 8'h01 << bp[i];
			@(posedge sys_clk) evt <= 12'h001 << i;
			@(posedge sys_clk) evt <= '0;
			// let the latching edge settle first
			#1 chk("summary up", 8'h01 << g, {5'h0, irq});
			host.rd(a, d);
			chk("flag", m, d);
			host.wr(a, 8'h00);
			host.rd(a, d);
			chk("flag kept", m, d);
			host.wr(a, m);
			host.rd(a, d);
			chk("flag cleared", 8'h00, d);
			chk("summary down", 8'h00, {5'h0, irq});
		end
	endtask
	task t_race;
		@(posedge sys_clk) evt <= 12'h040;
		host.wr(8'h23, 8'h01);
		evt <= '0;
		host.rd(8'h23, d);
		chk("event beats clear", 8'h01, d);
		host.wr(8'h23, 8'h01);
	endtask
	task t_top;
		host.rd(8'h25, d);
		chk("status reset", 8'h00, d);
		@(posedge sys_clk) live <= 4'ha;
		host.rd(8'h25, d);
		chk("status", 8'h0a, d);
		@(posedge sys_clk) live <= 4'h5;
		host.wr(8'h25, 8'hff);
		host.rd(8'h25, d);
		chk("status", 8'h05, d);
		host.rd(8'h30, d);
		chk("unmapped", 8'h00, d);
	endtask
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#100us;
		mismatches++;
		complete_run;
	end
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_rsv;
		t_flags;
		t_race;
		t_top;
		complete_run;
	end
endmodule // pfl_fault_latch_tb
